//--- src/uocc_core.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Force-peripheral bit 30 puts core in device role ignoring ID input.
// - Force-host bit 29 puts core in host role unless bit 30 is set; both zero means normal detection.
// - DMA bit and scatter/gather bit select slave, invalid, buffered or S/G.
// - Bit 9 enables host negotiation capability.
// - Session request bit 8 clear blocks B-device session requests.
// - Transceiver and interface select bits 6 and 4 read zero.
// - Bit 3 selects 8-bit or 16-bit PHY data path.
// - Host low-speed-only bit 2 limits enumeration to full/low speed.
// - Endpoint type bits 19:18: control, isochronous, bulk, interrupt.
// - Channel bit 15 direction, 14:11 endpoint, 10:0 max packet size.
// - Software loads first PID; host then advances it per transaction unless it is DATA2, which holds.
// - Periodic share field 25:24 reserves 25, 50 or 75 percent.
// - In S/G mode, periodic fetch for the share when active, else non-periodic only.
// - Device speed 1:0 requests high or full speed; settles after chirp.
// - Writing bits 29 or 28 sets a bulk or interrupt endpoint toggle to DATA1 or DATA0.
// - Global registers work in both roles and survive role change.
module uocc_core #(
  parameter int SETTLE_CYC = uocc_pkg::ROLE_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // PHY side
  input  wire logic        phyClk,
  input  wire logic        idPin,
  input  wire logic        periodicActive,
  input  wire logic        chirpDone,
  input  wire logic        chirpHigh,
  input  wire logic        txDone,
  // Status outputs
  output logic             hostRole,
  output logic             roleSettled,
  output uocc_pkg::uocc_mode_t dataMode,
  output logic             phyWide,
  output logic             negCapable,
  output logic             sessReqAllowed,
  output logic             highSpeedAllowed,
  output logic             fetchPeriodic,
  output logic [1:0]       channelPid,
  output logic             endpointToggle,
  output logic [1:0]       linkSpeed
);
  import uocc_pkg::*;
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] otgCtl;
    logic [31:0] busCfg;
    logic [31:0] phyCfg;
    logic [31:0] hostCfg;
    logic [31:0] hcChar;
    logic [31:0] hcTsiz;
    logic [31:0] devCfg;
    logic [31:0] epCtl;
    logic [31:0] rdata;
    logic        sgWritten;
    logic        hostRole;
    logic [31:0] settleCnt;
    logic        roleSettled;
    logic        phyPrev;
    logic        frameTick;
    logic        txPrev;
    logic        chirpPrev;
    logic [1:0]  linkSpeed;
    uocc_mode_t  dataMode;
    logic        fetchPeriodic;
  } uocc_core_t;
  uocc_core_t st;
  uocc_core_t next_st;
  logic [4:0] inSync;
  logic       sgNow;
  logic       wantHost;
  uocc_sched_if sif ();
  // ==========================================================
  // Pin synchronisers
  // The chirp speed level is a pin as well, so it goes through the same two stages
  uocc_sync #(.WIDTH(5)) u_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .async  ({chirpHigh, phyClk, idPin, txDone, chirpDone}),
    .synced (inSync)
  );
  uocc_sched u_sched (
    .mclk  (mclk),
    .rst_n (rst_n),
    .sif   (sif)
  );
  assign sif.frameTick      = st.frameTick;
  assign sif.share          = st.devCfg[25:24];
  assign sif.sgMode         = (st.dataMode == UOCC_SG_DMA);
  assign sif.periodicActive = periodicActive;
  // Decode helper used for both host and device S/G bits
  function automatic uocc_mode_t modeOf(input logic dma, input logic sg);
    case ({dma, sg})
      2'b00:   modeOf = UOCC_SLAVE;
      2'b01:   modeOf = UOCC_INVALID;
      2'b10:   modeOf = UOCC_BUF_DMA;
      default: modeOf = UOCC_SG_DMA;
    endcase
  endfunction : modeOf
  function automatic logic [1:0] pidNext(input logic [1:0] pid);
    pidNext = (pid == PID_DATA0) ? PID_DATA1 : PID_DATA0;
  endfunction : pidNext
  always_comb begin
    next_st = st;
    sgNow = st.hostRole ? st.hostCfg[BIT_SG_EN] : st.devCfg[BIT_SG_EN];
    // ========================================================
    // Role selection; ID high means B-device
    if (st.phyCfg[BIT_FORCE_PERIPH]) begin
      wantHost = 1'b0;
    end else if (st.phyCfg[BIT_FORCE_HOST]) begin
      wantHost = 1'b1;
    end else begin
      wantHost = ~inSync[2];
    end
    next_st.hostRole = wantHost;
    // Settle window so software reading status sees roleSettled low after any role change
    if (wantHost != st.hostRole) begin
      next_st.settleCnt   = 32'(SETTLE_CYC);
      next_st.roleSettled = 1'b0;
    end else if (st.settleCnt != 32'h00000000) begin
      next_st.settleCnt = st.settleCnt - 32'h00000001;
    end else begin
      next_st.roleSettled = 1'b1;
    end
    next_st.dataMode = modeOf(st.busCfg[BIT_DMA_EN], sgNow);
    // ========================================================
    // Link clock edges derive the frame position
    next_st.phyPrev   = inSync[3];
    next_st.frameTick = inSync[3] & ~st.phyPrev;
    // Host advances the PID after each completed transaction unless it holds DATA2
    next_st.txPrev = inSync[1];
    if (inSync[1] && !st.txPrev && st.hcTsiz[30:29] != PID_DATA2) begin
      next_st.hcTsiz[30:29] = pidNext(st.hcTsiz[30:29]);
    end
    // Actual speed only after the chirp handshake
    next_st.chirpPrev = inSync[0];
    if (inSync[0] && !st.chirpPrev) begin
      if (st.devCfg[1:0] == SPD_HIGH && inSync[4]) begin
        next_st.linkSpeed = SPD_HIGH;
      end else begin
        next_st.linkSpeed = (st.devCfg[1:0] == SPD_FULL48) ? SPD_FULL48 : 2'h1;
      end
    end
    next_st.fetchPeriodic = sif.fetchPeriodic;
    // ========================================================
    // Register writes
    if (regWrite) begin
      case (regAddr)
        ADDR_OTG_CTL: begin
          next_st.otgCtl[BIT_DEV_NEG_EN]  = regWdata[BIT_DEV_NEG_EN];
          next_st.otgCtl[BIT_HOST_NEG_EN] = regWdata[BIT_HOST_NEG_EN];
        end
        ADDR_BUS_CFG:  next_st.busCfg = regWdata & 32'h00000020;
        ADDR_PHY_CFG:  next_st.phyCfg = regWdata & 32'h60000308;
        ADDR_HOST_CFG: begin
          next_st.hostCfg[BIT_LS_ONLY] = regWdata[BIT_LS_ONLY];
          // Later changes would corrupt in-flight descriptors
          if (!st.sgWritten) begin
            next_st.hostCfg[BIT_SG_EN] = regWdata[BIT_SG_EN];
            next_st.sgWritten = 1'b1;
          end
        end
        ADDR_HC_CHAR:  next_st.hcChar = regWdata & 32'h000cffff;
        ADDR_HC_TSIZ:  next_st.hcTsiz = regWdata & 32'h60000000;
        ADDR_DEV_CFG: begin
          next_st.devCfg[25:24] = regWdata[25:24];
          next_st.devCfg[10:0]  = regWdata[10:0] & 11'h7f3;
          if (!st.sgWritten) begin
            next_st.devCfg[BIT_SG_EN] = regWdata[BIT_SG_EN];
            next_st.sgWritten = 1'b1;
          end
        end
        ADDR_EP_CTL: begin
          next_st.epCtl[19:18] = regWdata[19:18];
          next_st.epCtl[10:0]  = regWdata[10:0];
          if (regWdata[19]) begin
            if (regWdata[BIT_SET_ONE]) begin
              next_st.epCtl[BIT_TOGGLE] = 1'b1;
            end else if (regWdata[BIT_SET_ZERO]) begin
              next_st.epCtl[BIT_TOGGLE] = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // ========================================================
    // Register reads, data valid in the following cycle
    next_st.rdata = 32'h00000000;
    if (regRead) begin
      case (regAddr)
        ADDR_OTG_CTL:   next_st.rdata = st.otgCtl | (32'(inSync[2]) << BIT_CONN_ID);
        ADDR_BUS_CFG:   next_st.rdata = st.busCfg;
        ADDR_PHY_CFG:   next_st.rdata = st.phyCfg;
        ADDR_HOST_CFG:  next_st.rdata = st.hostCfg;
        ADDR_HC_CHAR:   next_st.rdata = st.hcChar;
        ADDR_HC_TSIZ:   next_st.rdata = st.hcTsiz;
        ADDR_DEV_CFG:   next_st.rdata = st.devCfg;
        ADDR_EP_CTL:    next_st.rdata = st.epCtl;
        ADDR_ROLE_STAT: next_st.rdata = {26'h0, st.linkSpeed, st.dataMode,
                                         st.roleSettled, st.hostRole};
        default:        next_st.rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================================
  // Outputs straight from state
  assign regRdata         = st.rdata;
  assign hostRole         = st.hostRole;
  assign roleSettled      = st.roleSettled;
  assign dataMode         = st.dataMode;
  assign phyWide          = st.phyCfg[BIT_PHY_WIDTH];
  assign negCapable       = st.phyCfg[BIT_NEG_CAP];
  assign sessReqAllowed   = st.phyCfg[BIT_SESS_CAP] & ~st.hostRole;
  assign highSpeedAllowed = ~st.hostCfg[BIT_LS_ONLY];
  assign fetchPeriodic    = st.fetchPeriodic;
  assign channelPid       = st.hcTsiz[30:29];
  assign endpointToggle   = st.epCtl[BIT_TOGGLE];
  assign linkSpeed        = st.linkSpeed;
endmodule : uocc_core

//--- src/uocc_pkg.sv
package uocc_pkg;
  // ==========================================================
  // Register indices (printed offsets are byte addresses)
  localparam logic [11:0] ADDR_OTG_CTL   = 12'h000;
  localparam logic [11:0] ADDR_BUS_CFG   = 12'h008;
  localparam logic [11:0] ADDR_PHY_CFG   = 12'h00c;
  localparam logic [11:0] ADDR_HOST_CFG  = 12'h400;
  localparam logic [11:0] ADDR_HC_CHAR   = 12'h500;
  localparam logic [11:0] ADDR_HC_TSIZ   = 12'h510;
  localparam logic [11:0] ADDR_DEV_CFG   = 12'h800;
  localparam logic [11:0] ADDR_EP_CTL    = 12'h900;
  localparam logic [11:0] ADDR_ROLE_STAT = 12'h010;
  // ==========================================================
  // Field positions
  localparam int BIT_DEV_NEG_EN   = 11;
  localparam int BIT_HOST_NEG_EN  = 10;
  localparam int BIT_CONN_ID      = 16;
  localparam int BIT_DMA_EN       = 5;
  localparam int BIT_FORCE_PERIPH = 30;
  localparam int BIT_FORCE_HOST   = 29;
  localparam int BIT_NEG_CAP      = 9;
  localparam int BIT_SESS_CAP     = 8;
  localparam int BIT_PHY_WIDTH    = 3;
  localparam int BIT_SG_EN        = 23;
  localparam int BIT_LS_ONLY      = 2;
  localparam int BIT_EP_DIR       = 15;
  localparam int BIT_SET_ONE      = 29;
  localparam int BIT_SET_ZERO     = 28;
  localparam int BIT_TOGGLE       = 16;
  // ==========================================================
  // Timing and frame
  localparam int  CLK_MHZ          = 125;
  localparam int  ROLE_SETTLE_US   = 25000;
  localparam int  ROLE_SETTLE_CYC  = ROLE_SETTLE_US * CLK_MHZ;
  localparam int  FRAME_LCLK       = 7500;
  localparam int  PHY_CLK_DIV      = 10;
  // ==========================================================
  typedef enum logic [1:0] {UOCC_SLAVE, UOCC_INVALID, UOCC_BUF_DMA, UOCC_SG_DMA} uocc_mode_t;
  typedef enum logic [1:0] {UOCC_CTRL, UOCC_ISO, UOCC_BULK, UOCC_INTR} uocc_endpoint_transfer_type_t;
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA2 = 2'h1;
  localparam logic [1:0] PID_DATA1 = 2'h2;
  localparam logic [1:0] SPD_HIGH  = 2'h0;
  localparam logic [1:0] SPD_FULL48 = 2'h3;
endpackage : uocc_pkg

//--- src/uocc_sched.sv
`timescale 1ns/10ps
module uocc_sched (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Scheduler link
  uocc_sched_if.sch sif
);
  import uocc_pkg::*;
  typedef struct packed {
    logic [12:0] pos;
    logic        fetchPeriodic;
  } uocc_sched_t;
  uocc_sched_t st;
  uocc_sched_t next_st;
  logic [12:0] limit;
  always_comb begin
    case (sif.share)
      2'h0:    limit = 13'(FRAME_LCLK / 4);
      2'h1:    limit = 13'(FRAME_LCLK / 2);
      2'h2:    limit = 13'(FRAME_LCLK * 3 / 4);
      default: limit = 13'h0000; // Reserved code grants no periodic share
    endcase
  end
  always_comb begin
    next_st = st;
    if (sif.frameTick) begin
      next_st.pos = (st.pos == 13'(FRAME_LCLK - 1)) ? 13'h0000 : st.pos + 13'h0001;
    end
    // In S/G mode, periodic fetch for the reserved share, then non-periodic
    next_st.fetchPeriodic = sif.sgMode && sif.periodicActive && (st.pos < limit);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign sif.fetchPeriodic = st.fetchPeriodic;
endmodule : uocc_sched

//--- src/uocc_sched_if.sv
`timescale 1ns/10ps
interface uocc_sched_if;
  import uocc_pkg::*;
  logic       frameTick;
  logic [1:0] share;
  logic       sgMode;
  logic       periodicActive;
  logic       fetchPeriodic;
  modport ctl (output frameTick, share, sgMode, periodicActive, input fetchPeriodic);
  modport sch (input frameTick, share, sgMode, periodicActive, output fetchPeriodic);
endinterface : uocc_sched_if

//--- src/uocc_sync.sv
`timescale 1ns/10ps
module uocc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  import uocc_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } uocc_sync_t;
  uocc_sync_t st;
  uocc_sync_t next_st;
  always_comb begin
    next_st.first  = async;
    next_st.second = st.first;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign synced = st.second;
endmodule : uocc_sync

//--- verification/uocc_core_props.sv
`timescale 1ns/10ps
module uocc_core_props
  import uocc_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  // Status
  input wire logic        periodicActive,
  input wire logic        hostRole,
  input wire logic        phyWide,
  input wire logic        negCapable,
  input wire logic        sessReqAllowed,
  input wire logic        highSpeedAllowed,
  input wire logic        fetchPeriodic,
  input wire logic [1:0]  channelPid,
  input wire logic        endpointToggle
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Sequences
  sequence s_wr(logic [11:0] a);
    regWrite && regAddr == a;
  endsequence
  sequence s_idle_periodic;
    !periodicActive [*6];
  endsequence
  property p_width;
    logic w;
    (s_wr(ADDR_PHY_CFG), w = regWdata[BIT_PHY_WIDTH]) |-> ##2 phyWide == w;
  endproperty
  property p_pid;
    logic [1:0] p;
    (s_wr(ADDR_HC_TSIZ), p = regWdata[30:29]) |-> ##2 channelPid == p;
  endproperty
  property p_toggle;
    logic t;
    (s_wr(ADDR_EP_CTL) ##0 (regWdata[19] && (regWdata[BIT_SET_ONE] || regWdata[BIT_SET_ZERO])),
     t = regWdata[BIT_SET_ONE]) |-> ##2 endpointToggle == t;
  endproperty
  // ==========================================================
  // Assertions
  a_force_periph_role: assert property (s_wr(ADDR_PHY_CFG) ##0 regWdata[BIT_FORCE_PERIPH] |-> ##[1:4] !hostRole) else $error("forced device role not taken");
  a_force_host_role: assert property (s_wr(ADDR_PHY_CFG) ##0 (regWdata[BIT_FORCE_HOST] && !regWdata[BIT_FORCE_PERIPH]) |-> ##[1:4] hostRole) else $error("forced host role not taken");
  a_phy_sel_zero: assert property (regRead && regAddr == ADDR_PHY_CFG |=> !regRdata[6] && !regRdata[4]) else $error("PHY select bits read nonzero");
  a_phy_width: assert property (p_width) else $error("PHY width does not follow write");
  a_neg_capable: assert property (s_wr(ADDR_PHY_CFG) |-> ##2 negCapable == $past(regWdata[BIT_NEG_CAP], 2)) else $error("negotiation capability wrong");
  a_sess_blocked: assert property (s_wr(ADDR_PHY_CFG) ##0 !regWdata[BIT_SESS_CAP] |-> ##2 !sessReqAllowed) else $error("session request allowed");
  a_ls_only: assert property (s_wr(ADDR_HOST_CFG) ##0 regWdata[BIT_LS_ONLY] |-> ##2 !highSpeedAllowed) else $error("high speed still allowed");
  a_pid_load: assert property (p_pid) else $error("channel PID not loaded");
  a_toggle_set: assert property (p_toggle) else $error("endpoint toggle not set");
  a_no_periodic: assert property (s_idle_periodic |-> !fetchPeriodic) else $error("periodic fetch while idle");
endmodule : uocc_core_props

//--- verification/uocc_core_tb_top.sv
`timescale 1ns/10ps
module uocc_core_tb_top;
  import uocc_pkg::*;
  localparam int SETTLE = 50;
  logic        mclk, rst_n, regWrite, regRead, idPin, periodicActive, run;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, q;
  logic        phyClk, chirpDone, chirpHigh, txDone, hostRole, roleSettled, phyWide;
  logic        negCapable, sessReqAllowed, highSpeedAllowed, fetchPeriodic, endpointToggle;
  logic [1:0]  channelPid, linkSpeed;
  uocc_mode_t  dataMode;
  int          miscompares, check_count;
  initial {mclk, rst_n, regWrite, regRead, periodicActive, run, regAddr, regWdata} = '0;
  initial idPin = 1'b1;
  always #4 mclk = ~mclk;
  uocc_core #(.SETTLE_CYC(SETTLE)) u_uocc_core (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .phyClk(phyClk), .idPin(idPin), .periodicActive(periodicActive), .chirpDone(chirpDone),
    .chirpHigh(chirpHigh), .txDone(txDone), .hostRole(hostRole), .roleSettled(roleSettled),
    .dataMode(dataMode), .phyWide(phyWide), .negCapable(negCapable),
    .sessReqAllowed(sessReqAllowed), .highSpeedAllowed(highSpeedAllowed),
    .fetchPeriodic(fetchPeriodic), .channelPid(channelPid), .endpointToggle(endpointToggle),
    .linkSpeed(linkSpeed));
  uocc_phy_model u_uocc_phy_model (.run(run), .phyClk(phyClk), .chirpDone(chirpDone),
    .chirpHigh(chirpHigh), .txDone(txDone));
  // ==========================================================
  // Bus and check tasks; an idle cycle after each strobe avoids double drives
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    step(1);
    regWrite <= 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    step(1);
    regRead <= 1'b0;
    q = regRdata;
    step(1);
  endtask : rd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic do_reset(input int n);
    rst_n <= 1'b0;
    step(n);
    rst_n <= 1'b1;
    step(1);
  endtask : do_reset
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_PHY_CFG, i ? 32'h0 : 32'h0000_037f);
      wr(ADDR_HOST_CFG, i ? 32'h0 : 32'h0000_0004);
      rd(ADDR_PHY_CFG);
      chk(q & 32'h0000_0358, i ? 32'h0 : 32'h0000_0308);
      chk({phyWide, negCapable, sessReqAllowed}, i ? 3'h0 : 3'h7);
      chk(highSpeedAllowed, i);
    end
    wr(ADDR_HC_CHAR, 32'h000c_d840);
    rd(ADDR_HC_CHAR);
    chk(q & 32'h000f_ffff, 32'h000c_d840);
    rd(12'h0fc);
    chk(q, 32'h0);
    wr(ADDR_DEV_CFG, 32'h0000_0550);
    rd(ADDR_DEV_CFG);
    chk(q & 32'h0000_07f0, 32'h0000_0550);
    wr(ADDR_EP_CTL, 32'h0000_0200);
    rd(ADDR_EP_CTL);
    chk(q & 32'h000c_07ff, 32'h0000_0200);
    wr(ADDR_BUS_CFG, 32'h0000_0020);
    rd(ADDR_BUS_CFG);
    chk(q, 32'h0000_0020);
  endtask : t_regs
  task automatic t_roles();
    logic [3:0] c [5] = '{4'b1000, 4'b0001, 4'b1011, 4'b0100, 4'b1110};
    wr(ADDR_OTG_CTL, 32'h0000_0c00);
    for (int i = 0; i < 5; i++) begin
      idPin <= c[i][3];
      wr(ADDR_PHY_CFG, {1'b0, c[i][2:1], 29'h0});
      step(4);
      chk(hostRole, c[i][0]);
      step(SETTLE + 8);
      rd(ADDR_ROLE_STAT);
      chk(q[1:0], {1'b1, c[i][0]});
    end
    rd(ADDR_OTG_CTL);
    chk(q & 32'h0000_0c00, 32'h0000_0c00);
    idPin <= 1'b1;
    wr(ADDR_PHY_CFG, 32'h0);
  endtask : t_roles
  task automatic t_pid();
    logic [1:0] ld [3] = '{2'h0, 2'h2, 2'h1};
    logic [1:0] nx [3] = '{2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_HC_TSIZ, {1'b0, ld[i], 29'h0});
      step(2);
      chk(channelPid, ld[i]);
      u_uocc_phy_model.tx();
      step(4);
      chk(channelPid, nx[i]);
    end
  endtask : t_pid
  task automatic t_toggle();
    logic [31:0] d [5] = '{32'h2008_0000, 32'h1008_0000, 32'h200c_0000, 32'h1000_0000,
                           32'h1004_0000};
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_EP_CTL, d[i]);
      step(2);
      chk(endpointToggle, (i != 1));
    end
  endtask : t_toggle
  task automatic t_speed();
    logic [1:0] req [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
    logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h1, 2'h3};
    logic       hs [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DEV_CFG, {30'h0, req[i]});
      step(3);
      chk(linkSpeed, i ? exp[i-1] : 2'h0);
      u_uocc_phy_model.chirp(hs[i]);
      step(4);
      chk(linkSpeed, exp[i]);
    end
  endtask : t_speed
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      do_reset(2);
      wr(ADDR_BUS_CFG, 32'(m[1]) << BIT_DMA_EN);
      wr(ADDR_DEV_CFG, 32'(m[0]) << BIT_SG_EN);
      wr(ADDR_HOST_CFG, 32'(!m[0]) << BIT_SG_EN);
      step(2);
      chk(dataMode, m);
    end
  endtask : t_modes
  // Quarter share of a 7500-edge frame, allowing for synchroniser latency
  task automatic t_sched();
    int n;
    periodicActive <= 1'b1;
    run <= 1'b1;
    n = 0;
    while (fetchPeriodic !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      summarize();
    end
    n = 0;
    while (fetchPeriodic === 1'b1 && n < 3000) begin
      @(posedge phyClk);
      n++;
    end
    chk(n >= 1872 && n <= 1878, 1'b1);
    periodicActive <= 1'b0;
    step(8);
    chk(fetchPeriodic, 1'b0);
    run <= 1'b0;
  endtask : t_sched
  initial begin
    do_reset(20);
    t_regs();
    t_roles();
    t_pid();
    t_toggle();
    t_speed();
    t_modes();
    t_sched();
    summarize();
  end
endmodule : uocc_core_tb_top
bind uocc_core uocc_core_props u_uocc_core_props (.mclk(mclk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .periodicActive(periodicActive), .hostRole(hostRole),
  .phyWide(phyWide), .negCapable(negCapable), .sessReqAllowed(sessReqAllowed),
  .highSpeedAllowed(highSpeedAllowed), .fetchPeriodic(fetchPeriodic),
  .channelPid(channelPid), .endpointToggle(endpointToggle));

//--- verification/uocc_phy_model.sv
`timescale 1ns/10ps
module uocc_phy_model (
  // Control
  input wire logic run,
  // Link side
  output logic     phyClk,
  output logic     chirpDone,
  output logic     chirpHigh,
  output logic     txDone
);
  // Link clock stands still outside traffic; offset keeps it unrelated to mclk
  initial begin
    phyClk = 1'b0;
    chirpDone = 1'b0;
    chirpHigh = 1'b0;
    txDone = 1'b0;
    #3;
    forever begin
      #40;
      if (run || phyClk) phyClk = ~phyClk;
    end
  end
  task automatic chirp(input logic hs);
    chirpHigh = hs;
    #20 chirpDone = 1'b1;
    #200 chirpDone = 1'b0;
  endtask : chirp
  task automatic tx();
    #5 txDone = 1'b1;
    #100 txDone = 1'b0;
    #100;
  endtask : tx
endmodule : uocc_phy_model
